/* hdl/pin_sync.sv */
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the inputs come from pins outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH     = 2,             // Number of lines
  parameter logic [WIDTH-1:0] INIT = '1             // Value held in reset
) (
  input  wire logic             clk,                // System clock
  input  wire logic             rst_n,              // Synchronous reset
  input  wire logic [WIDTH-1:0] async_in,           // Raw pin levels
  output var  logic [WIDTH-1:0] sync_out            // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;                         // First stage, read only below

  // ------------------------------------------------------------
  // Two stages; nothing but the second stage reads the first
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q   <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pin_sync
`default_nettype wire

/* hdl/prio_pick.sv */
// Two-level fixed-order picker: high level first, then lowest index.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module prio_pick
  import irq_dispatch_pkg::*;
#(
  parameter int unsigned N = SRC_COUNT              // Number of sources
) (
  input  wire logic [N-1:0]     req,                // Eligible requests
  input  wire logic [N-1:0]     high,               // Level of each source
  output var  logic             found,              // Some request chosen
  output var  logic [IDX_W-1:0] index,              // Chosen index
  output var  logic             is_high             // Chosen one is high
);

  // ------------------------------------------------------------
  // Scan from the top so the lowest index wins each level
  // ------------------------------------------------------------
  always_comb begin
    logic [IDX_W-1:0] lo_idx;
    logic [IDX_W-1:0] hi_idx;
    logic             lo_hit;
    logic             hi_hit;
    lo_idx = '0;
    hi_idx = '0;
    lo_hit = 1'b0;
    hi_hit = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && high[i]) begin
        hi_idx = IDX_W'(i);
        hi_hit = 1'b1;
      end
      if (req[i] && !high[i]) begin
        lo_idx = IDX_W'(i);
        lo_hit = 1'b1;
      end
    end
    found   = hi_hit || lo_hit;
    is_high = hi_hit;
    index   = hi_hit ? hi_idx : lo_idx;
  end

endmodule // prio_pick
`default_nettype wire

/* hdl/two_level_interrupt_dispatch.sv */
// Interrupt dispatcher of an 8-bit core: enable registers, the four
// hardware-cleared pending flags, two-level arbitration and call timing.
// Assumes peripheral pending lines and CPU strobes share clk; the two
// external pins are asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_dispatch
  import irq_dispatch_pkg::*;
(
  input  wire logic                   clk,                  // System clock
  input  wire logic                   rst_n,                // Sync reset, low
  // Special function register port
  input  wire logic [7:0]             sfr_addr,             // Direct address
  input  wire logic                   sfr_wr,               // Byte write strobe
  input  wire logic [7:0]             sfr_wdata,            // Byte write data
  input  wire logic                   sfr_bit_wr,           // Single-bit write
  input  wire logic [2:0]             sfr_bit_pos,          // Bit position
  input  wire logic                   sfr_bit_val,          // Bit value
  input  wire logic                   sfr_rd,               // Read strobe
  output var  logic [7:0]             sfr_rdata_q,          // Read data
  output var  logic                   sfr_hit_q,            // Read was mapped
  // Sources
  input  wire logic                   ext_irq_zero_pin,     // Pin, active low
  input  wire logic                   ext_irq_one_pin,      // Pin, active low
  input  wire logic                   timer_zero_ovf,       // Overflow pulse
  input  wire logic                   timer_one_ovf,        // Overflow pulse
  input  wire logic [HW_FLAGS-1:0]    flag_sw_set,          // Software sets
  input  wire logic [HW_FLAGS-1:0]    flag_sw_clr,          // Software clears
  output var  logic [HW_FLAGS-1:0]    hw_flags_q,           // Held flags
  input  wire logic                   uart_zero_pend,       // UART pending
  input  wire logic                   timer_two_low_overflow,   // Timer 2 low
  input  wire logic                   timer_two_high_overflow,  // Timer 2 high
  input  wire logic                   serial_port_zero_pend,    // Serial 0
  input  wire logic [PERIPH_SRCS-1:0] periph_pend,          // Indices 7..14
  input  wire logic                   supply_good_flag,     // Read-only, low=warn
  input  wire logic                   port_match_pend,      // Port match
  input  wire logic                   rtc_osc_fail_flag,    // Indirect space
  input  wire logic                   radio_spi_pend,       // Radio serial port
  input  wire logic [EXT2_SRCS-1:0]   ext_mask_two,         // Masks 15..18
  input  wire logic [SRC_COUNT-1:0]   prio_high,            // Level per source
  // CPU sequencing
  input  wire logic                   instr_done,           // Instruction ends
  input  wire logic                   instr_is_return_from_irq_instr,        // It was a return
  output var  logic                   vector_call_q,        // Call start pulse
  output var  logic                   call_busy_q,          // Call in progress
  output var  logic [15:0]            vector_addr_q,        // Call target
  output var  logic                   low_active_q,         // Low routine runs
  output var  logic                   high_active_q,        // High routine runs
  output var  logic [7:0]             interrupt_enable_mask_q // Enable register
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0]              extended_mask_one_q;  // First extended mask
  logic [1:0]              pin_sync_lvl;         // Synchronised pins
  logic [1:0]              pin_prev_q;           // Previous pin level
  logic [1:0]              pin_fall;             // Falling edge seen
  logic [SRC_COUNT-1:0]    pend;                 // All pending flags
  logic [SRC_COUNT-1:0]    mask;                 // All per-source masks
  logic [SRC_COUNT-1:0]    eligible;             // Gated and unblocked
  logic                    pick_found;           // Arbiter has a winner
  logic [IDX_W-1:0]        pick_index;           // Winning index
  logic                    pick_high;            // Winner is high level
  dispatch_state_type      state_q;              // Dispatcher state
  logic [CNT_W-1:0]        call_cnt_q;           // Cycles left in call
  logic                    reset_pend_q;         // Reset vector owed
  logic                    call_high_q;          // Level of current call
  logic                    take_call;            // Call starts now
  logic [HW_FLAGS-1:0]     hw_clear;             // Cleared by vectoring
  logic [HW_FLAGS-1:0]     hw_event;             // Hardware set events

  // Vector address of a source index
  function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
    vector_of = VEC_BASE + (VEC_STEP * {11'h000, idx});
  endfunction

  // Whether an address selects a given register; page is ignored
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
    addr_is = (a == r);
  endfunction

  // ------------------------------------------------------------
  // Enable registers
  // ------------------------------------------------------------
  // Both registers answer on every page, so no page input exists
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interrupt_enable_mask_q <= ENABLE_RESET;
    end else if (sfr_wr && addr_is(sfr_addr, ADDR_IRQ_ENABLE)) begin
      interrupt_enable_mask_q <= sfr_wdata;
    end else if (sfr_bit_wr && addr_is(sfr_addr, ADDR_IRQ_ENABLE)) begin
      interrupt_enable_mask_q[sfr_bit_pos] <= sfr_bit_val;
    end
  end

  // Extended mask is byte access only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extended_mask_one_q <= EXT_MASK1_RESET;
    end else if (sfr_wr && addr_is(sfr_addr, ADDR_EXT_MASK1)) begin
      extended_mask_one_q <= sfr_wdata;
    end
  end

  // Read port; unmapped addresses return zero with no hit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata_q <= RDATA_IDLE;
      sfr_hit_q   <= 1'b0;
    end else if (sfr_rd && addr_is(sfr_addr, ADDR_IRQ_ENABLE)) begin
      sfr_rdata_q <= interrupt_enable_mask_q;
      sfr_hit_q   <= 1'b1;
    end else if (sfr_rd && addr_is(sfr_addr, ADDR_EXT_MASK1)) begin
      sfr_rdata_q <= extended_mask_one_q;
      sfr_hit_q   <= 1'b1;
    end else begin
      sfr_rdata_q <= RDATA_IDLE;
      sfr_hit_q   <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // External pins and hardware-cleared flags
  // ------------------------------------------------------------
  pin_sync #(
    .WIDTH (2),
    .INIT  (2'h3)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({ext_irq_one_pin, ext_irq_zero_pin}),
    .sync_out (pin_sync_lvl)
  );

  // Edge detect on the synchronised copy, never on the first stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_prev_q <= 2'h3;
    end else begin
      pin_prev_q <= pin_sync_lvl;
    end
  end

  assign pin_fall = pin_prev_q & ~pin_sync_lvl;

  // Events in index order: ext0, timer0, ext1, timer1
  assign hw_event = {timer_one_ovf, pin_fall[1], timer_zero_ovf, pin_fall[0]};

  // Flags set regardless of enables; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hw_flags_q <= '0;
    end else begin
      hw_flags_q <= (hw_flags_q & ~(hw_clear | flag_sw_clr))
                  | hw_event | flag_sw_set;
    end
  end

  // Vectoring to one of these four sources clears its own flag
  always_comb begin
    hw_clear = '0;
    if (take_call && !reset_pend_q && (pick_index < IDX_W'(HW_FLAGS))) begin
      hw_clear[pick_index[1:0]] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Pending and mask vectors in fixed order
  // ------------------------------------------------------------
  // Other flags are owned by their peripherals and cleared by software
  assign pend = {radio_spi_pend,
                 rtc_osc_fail_flag,
                 port_match_pend,
                 ~supply_good_flag,
                 periph_pend,
                 serial_port_zero_pend,
                 timer_two_low_overflow | timer_two_high_overflow,
                 uart_zero_pend,
                 hw_flags_q};

  assign mask = {ext_mask_two,
                 extended_mask_one_q,
                 interrupt_enable_mask_q[BASIC_SRCS-1:0]};

  // Gate, mask, flag; a running high routine blocks all, a low one
  // blocks everything but high-level sources
  always_comb begin
    for (int i = 0; i < SRC_COUNT; i++) begin
      eligible[i] = interrupt_enable_mask_q[GATE_BIT]
                  && mask[i] && pend[i]
                  && !high_active_q
                  && (prio_high[i] || !low_active_q);
    end
  end

  // Decoded afresh every clock
  prio_pick #(
    .N (SRC_COUNT)
  ) u_prio_pick (
    .req     (eligible),
    .high    (prio_high),
    .found   (pick_found),
    .index   (pick_index),
    .is_high (pick_high)
  );

  // A call never starts at the end of a return: the instruction after
  // it must run first, which keeps a still-set flag from starving code
  assign take_call = (state_q == ST_IDLE && reset_pend_q)
                   || (state_q == ST_WAIT && pick_found
                       && instr_done && !instr_is_return_from_irq_instr);

  // ------------------------------------------------------------
  // Dispatch sequence
  // ------------------------------------------------------------
  // Idle detects (one cycle), wait covers the current instruction,
  // call holds for the five cycles of the vector call
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take_call) begin
            state_q <= ST_CALL;
          end else if (pick_found) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (take_call) begin
            state_q <= ST_CALL;
          end else if (!pick_found) begin
            state_q <= ST_IDLE;                             // Withdrawn
          end
        end
        ST_CALL: begin
          if (call_cnt_q == CNT_ONE) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Call length counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      call_cnt_q <= CNT_ZERO;
    end else if (take_call) begin
      call_cnt_q <= CNT_WIDTH_FIX(CALL_LAST) + CNT_ONE;
    end else if (call_cnt_q != CNT_ZERO) begin
      call_cnt_q <= call_cnt_q - CNT_ONE;
    end
  end

  // Identity helper keeps the counter width explicit
  function automatic logic [CNT_W-1:0] CNT_WIDTH_FIX(input logic [CNT_W-1:0] v);
    CNT_WIDTH_FIX = v;
  endfunction

  // Call outputs; the address is held until the next call
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vector_call_q <= 1'b0;
      call_busy_q   <= 1'b0;
      vector_addr_q <= VEC_RESET;
    end else begin
      vector_call_q <= take_call;
      call_busy_q   <= take_call || (call_cnt_q > CNT_ONE);
      if (take_call) begin
        vector_addr_q <= reset_pend_q ? VEC_RESET
                                      : vector_of(pick_index);
      end
    end
  end

  // Reset owes one call to address zero ahead of every source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_pend_q <= 1'b1;
    end else if (take_call) begin
      reset_pend_q <= 1'b0;
    end
  end

  // Level of the call being made
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      call_high_q <= 1'b0;
    end else if (take_call) begin
      call_high_q <= pick_high && !reset_pend_q;
    end
  end

  // ------------------------------------------------------------
  // In-service levels
  // ------------------------------------------------------------
  // A return ends the innermost routine: high if one runs, else low;
  // a preempted low routine therefore resumes after the high one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_active_q  <= 1'b0;
      high_active_q <= 1'b0;
    end else if (vector_call_q && !vector_addr_q[0] && vector_addr_q == VEC_RESET) begin
      low_active_q  <= low_active_q;                        // Reset is no routine
      high_active_q <= high_active_q;
    end else if (vector_call_q) begin
      high_active_q <= high_active_q || call_high_q;
      low_active_q  <= low_active_q || !call_high_q;
    end else if (instr_done && instr_is_return_from_irq_instr) begin
      if (high_active_q) begin
        high_active_q <= 1'b0;
      end else begin
        low_active_q  <= 1'b0;
      end
    end
  end

endmodule // two_level_interrupt_dispatch
`default_nettype wire

/* inc/irq_dispatch_pkg.sv */
// Constants, types and field layout of the two-level interrupt dispatcher.
// Assumes one system clock and a synchronous active-low reset.
package irq_dispatch_pkg;

  // ------------------------------------------------------------
  // Source map
  // ------------------------------------------------------------
  localparam int unsigned SRC_COUNT  = 19;  // Fixed order indices 0..18
  localparam int unsigned IDX_W      = 5;   // Width of a source index
  localparam int unsigned HW_FLAGS   = 4;   // Hardware-cleared flags
  localparam int unsigned BASIC_SRCS = 7;   // Sources masked in the enable reg
  localparam int unsigned EXT1_SRCS  = 8;   // Sources in first extended mask
  localparam int unsigned EXT2_SRCS  = 4;   // Sources in second extended mask
  localparam int unsigned PERIPH_SRCS = 8;  // Generic pending lines, index 7..14

  localparam logic [IDX_W-1:0] IDX_EXT0  = 5'h00;
  localparam logic [IDX_W-1:0] IDX_TMR0  = 5'h01;
  localparam logic [IDX_W-1:0] IDX_EXT1  = 5'h02;
  localparam logic [IDX_W-1:0] IDX_TMR1  = 5'h03;

  // ------------------------------------------------------------
  // Registers and fields
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;  // interrupt_enable_mask
  localparam logic [7:0] ADDR_EXT_MASK1  = 8'hE6;  // extended_mask_one
  localparam logic [7:0] ENABLE_RESET    = 8'h00;
  localparam logic [7:0] EXT_MASK1_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE      = 8'h00;
  localparam int unsigned GATE_BIT       = 7;      // global_irq_gate

  // ------------------------------------------------------------
  // Vectors and timing (system clock cycles)
  // ------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam logic [15:0] VEC_STEP  = 16'h0008;
  localparam int unsigned CALL_CYCLES = 5;   // Length of the vector call
  localparam int unsigned CNT_W       = 3;
  localparam logic [CNT_W-1:0] CALL_LAST = CNT_W'(CALL_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;

  // Dispatcher sequence
  typedef enum logic [1:0] {
    ST_IDLE,   // Decoding, nothing chosen
    ST_WAIT,   // Request detected, waiting for the instruction to end
    ST_CALL    // Vector call in progress
  } dispatch_state_type;

endpackage

/* tb/cpu_model.sv */
// Behavioural CPU sequencer: instructions of a set length, returns on request.
// Assumes the dispatcher's busy flag marks the vector call.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic       clk,          // System clock
  input  wire logic       rst_n,        // Sync reset
  input  wire logic       call_busy_q,  // Vector call running
  input  wire logic       return_from_irq_instr_req,     // Next instruction returns
  input  wire logic [3:0] instr_len,    // Cycles per instruction
  output var  logic       instr_done,   // Instruction ends
  output var  logic       instr_is_return_from_irq_instr // It was a return
);
  logic [3:0] cnt_q; // Cycles spent in the current instruction
  // Nothing executes during the call; >= lets a shorter length end at once
  assign instr_done = rst_n && !call_busy_q && (cnt_q >= instr_len - 4'h1);
  assign instr_is_return_from_irq_instr = instr_done && return_from_irq_instr_req;
  // Instruction cycle counter
  always_ff @(posedge clk) begin
    if (!rst_n || instr_done || call_busy_q) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
endmodule // cpu_model
`default_nettype wire

/* tb/dispatch_monitor.sv */
// Checker of call timing, gating and the enable register port.
// Assumes it is bound into every dispatcher and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dispatch_monitor (
  input wire logic        clk,                    // System clock
  input wire logic        rst_n,                  // Sync reset
  input wire logic [7:0]  sfr_addr,               // Address
  input wire logic        sfr_wr,                 // Write strobe
  input wire logic [7:0]  sfr_wdata,              // Write data
  input wire logic        sfr_rd,                 // Read strobe
  input wire logic [7:0]  sfr_rdata_q,            // Read data
  input wire logic        sfr_hit_q,              // Mapped read
  input wire logic [3:0]  hw_flags_q,             // Held flags
  input wire logic        vector_call_q,          // Call pulse
  input wire logic        call_busy_q,            // Call busy
  input wire logic [15:0] vector_addr_q,          // Call target
  input wire logic        high_active_q,          // High routine
  input wire logic [7:0]  interrupt_enable_mask_q // Enable register
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Call sequence: five busy cycles, then released
  sequence s_busy_run;
    call_busy_q [*5] ##1 !call_busy_q;
  endsequence
  a_call_single: assert property (vector_call_q |=> !vector_call_q)
    else $error("call pulse longer than one cycle");
  a_busy_five: assert property ($rose(call_busy_q) |-> s_busy_run)
    else $error("call busy not five cycles");
  a_reset_vector: assert property ($rose(rst_n) |-> ##[1:2] (vector_call_q && vector_addr_q == 16'h0000))
    else $error("no reset call to zero");
  a_vector_form: assert property (vector_call_q && vector_addr_q != 16'h0000 |->
    vector_addr_q[2:0] == 3'h3 && vector_addr_q <= 16'h0093) else $error("bad vector address");
  a_gate_needed: assert property (vector_call_q && vector_addr_q != 16'h0000 |-> $past(interrupt_enable_mask_q[7]))
    else $error("call with global gate off");
  a_no_preempt: assert property (vector_call_q |-> !$past(high_active_q))
    else $error("high routine preempted");
  a_flag_clear: assert property (vector_call_q && vector_addr_q == 16'h000B |-> !hw_flags_q[1])
    else $error("timer zero flag not cleared");
  a_write_seen: assert property (sfr_wr && sfr_addr == 8'hA8 |=> interrupt_enable_mask_q == $past(sfr_wdata))
    else $error("enable write lost");
  a_read_back: assert property (sfr_rd && sfr_addr == 8'hA8 && !sfr_wr |=>
    sfr_hit_q && sfr_rdata_q == $past(interrupt_enable_mask_q)) else $error("enable read wrong");
  a_unmapped_read: assert property (sfr_rd && sfr_addr != 8'hA8 && sfr_addr != 8'hE6 |=>
    !sfr_hit_q && sfr_rdata_q == 8'h00) else $error("unmapped read answered");
endmodule // dispatch_monitor
bind two_level_interrupt_dispatch dispatch_monitor i_dispatch_monitor (.clk, .rst_n, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rd, .sfr_rdata_q, .sfr_hit_q, .hw_flags_q, .vector_call_q, .call_busy_q, .vector_addr_q,
  .high_active_q, .interrupt_enable_mask_q);
`default_nettype wire

/* tb/tb_two_level_interrupt_dispatch.sv */
// Bench: enable register port, gating, latency, levels and vectors.
// Assumes cpu_model stands on the CPU side; pins stay idle high until pin one is driven low near the end.
`timescale 1ns/1ps
`default_nettype none
module tb_two_level_interrupt_dispatch
  import irq_dispatch_pkg::*;
;
  logic clk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, return_from_irq_instr_req, ext_irq_zero_pin, ext_irq_one_pin;
  logic timer_zero_ovf, timer_one_ovf, uart_zero_pend, timer_two_low_overflow, timer_two_high_overflow;
  logic serial_port_zero_pend, supply_good_flag, port_match_pend, rtc_osc_fail_flag, radio_spi_pend;
  logic [7:0] sfr_addr, sfr_wdata, periph_pend, sfr_rdata_q, interrupt_enable_mask_q;
  logic [3:0] flag_sw_set, flag_sw_clr, ext_mask_two, instr_len, hw_flags_q;
  logic [2:0] sfr_bit_pos;
  logic [SRC_COUNT-1:0] prio_high;
  logic [15:0] vector_addr_q;
  logic sfr_hit_q, instr_done, instr_is_return_from_irq_instr, vector_call_q, call_busy_q, low_active_q, high_active_q;
  int fails = 0, samples_checked = 0, calls = 0;
  two_level_interrupt_dispatch i_two_level_interrupt_dispatch (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_bit_wr, .sfr_bit_pos, .sfr_bit_val, .sfr_rd, .sfr_rdata_q, .sfr_hit_q, .ext_irq_zero_pin,
    .ext_irq_one_pin, .timer_zero_ovf, .timer_one_ovf, .flag_sw_set, .flag_sw_clr, .hw_flags_q, .uart_zero_pend,
    .timer_two_low_overflow, .timer_two_high_overflow, .serial_port_zero_pend, .periph_pend, .supply_good_flag,
    .port_match_pend, .rtc_osc_fail_flag, .radio_spi_pend, .ext_mask_two, .prio_high, .instr_done,
    .instr_is_return_from_irq_instr, .vector_call_q, .call_busy_q, .vector_addr_q, .low_active_q, .high_active_q,
    .interrupt_enable_mask_q);
  cpu_model i_cpu_model (.clk, .rst_n, .call_busy_q, .return_from_irq_instr_req, .instr_len, .instr_done, .instr_is_return_from_irq_instr);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Calls seen, counted at the edge after each pulse
  always @(posedge clk) if (vector_call_q === 1'b1) calls++;
  task automatic tick; @(posedge clk); #1; endtask
  task automatic conclude;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Byte write, or bit write of d[0] at position p
  task automatic wr(input logic [7:0] d, input logic bitw, input logic [2:0] p);
    sfr_addr = ADDR_IRQ_ENABLE;
    {sfr_wdata, sfr_bit_pos, sfr_bit_val, sfr_wr, sfr_bit_wr} = {d, p, d[0], !bitw, bitw};
    tick;
    {sfr_wr, sfr_bit_wr} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic hit);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    tick;
    sfr_rd = 1'b0;
    chk({7'h00, sfr_hit_q, sfr_rdata_q}, {7'h00, hit, d});
  endtask
  // Bounded wait for a call; n_exp < 0 skips the latency compare
  task automatic wait_call(input logic [15:0] exp, input int n_exp);
    int n;
    n = 0;
    while (vector_call_q !== 1'b1 && n < 40) begin tick; n++; end
    if (n == 40) begin fails++; conclude; end
    chk(vector_addr_q, exp);
    if (n_exp >= 0) chk(16'(n), 16'(n_exp));
  endtask
  // Return from the routine, then run instructions of next_len cycles
  task automatic return_from_irq_instr(input logic [3:0] next_len);
    int n;
    {return_from_irq_instr_req, instr_len, n} = {1'b1, 4'h1, 32'd0};
    while (instr_done !== 1'b1 && n < 40) begin tick; n++; end
    tick;
    {return_from_irq_instr_req, instr_len} = {1'b0, next_len};
    if (n == 40) begin fails++; conclude; end
  endtask
  initial begin
    {rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, return_from_irq_instr_req, timer_zero_ovf, timer_one_ovf} = '0;
    {uart_zero_pend, timer_two_low_overflow, timer_two_high_overflow, serial_port_zero_pend} = '0;
    {port_match_pend, rtc_osc_fail_flag, radio_spi_pend, sfr_addr, sfr_wdata, periph_pend, sfr_bit_pos} = '0;
    {flag_sw_set, flag_sw_clr, ext_mask_two, prio_high, instr_len} = {31'h0, 4'h1};
    {ext_irq_zero_pin, ext_irq_one_pin, supply_good_flag} = 3'b111;
    repeat (8) tick;
    rst_n = 1'b1;
    wait_call(VEC_RESET, -1);
    rd(ADDR_IRQ_ENABLE, 8'h00, 1'b1);
    wr(8'h70, 1'b0, 3'h0);
    uart_zero_pend = 1'b1;
    repeat (20) tick;
    chk(16'(calls), 16'h0001);
    // Supply warning pending at high level but left masked, so it must never win
    {supply_good_flag, prio_high[15]} = 2'b01;
    wr(8'h01, 1'b1, 3'h7);
    wait_call(16'h0023, 2);
    rd(ADDR_IRQ_ENABLE, 8'hF0, 1'b1);
    timer_two_high_overflow = 1'b1;
    repeat (12) tick;
    chk(16'(calls), 16'h0002);
    return_from_irq_instr(4'h8);
    wait_call(16'h0023, 8);
    {uart_zero_pend, serial_port_zero_pend} = 2'b01;
    return_from_irq_instr(4'h1);
    wait_call(16'h002B, -1);
    prio_high[1] = 1'b1;
    wr(8'h01, 1'b1, 3'h1);
    timer_zero_ovf = 1'b1;
    tick;
    timer_zero_ovf = 1'b0;
    wait_call(16'h000B, -1);
    chk({12'h000, hw_flags_q}, 16'h0000);
    // In-service levels follow the call pulse by one cycle
    tick;
    chk({14'h0, high_active_q, low_active_q}, 16'h0003);
    timer_zero_ovf = 1'b1;
    tick;
    timer_zero_ovf = 1'b0;
    repeat (12) tick;
    chk(16'(calls), 16'h0005);
    return_from_irq_instr(4'h1);
    wait_call(16'h000B, -1);
    return_from_irq_instr(4'h1);
    repeat (10) tick;
    chk({14'h0, high_active_q, low_active_q}, 16'h0001);
    // Falling pin edge with its mask off still sets the held flag
    ext_irq_one_pin = 1'b0;
    repeat (4) tick;
    chk({12'h000, hw_flags_q}, 16'h0004);
    chk(16'(calls), 16'h0006);
    rd(ADDR_EXT_MASK1, 8'h00, 1'b1);
    rd(8'h55, 8'h00, 1'b0);
    conclude;
  end
endmodule // tb_two_level_interrupt_dispatch
`default_nettype wire
